/* File: hdl/idaa_pkg.sv */
package idaa_pkg;
    // ****************************************
    // array geometry
    // ****************************************
    localparam int ENTRY_COUNT = 800; // words in the shared array
    localparam int WORD_WIDTH = 32; // bits per entry
    localparam int INDEX_WIDTH = 32; // width of the index parameter
    localparam int ADDR_WIDTH = 10; // bits to address one entry
    localparam logic [31:0] CAPACITY_VALUE = 32'h0000_0320; // reads as 800
    localparam logic [31:0] INDEX_RESET = 32'h0000_0000; // index after reset
    localparam logic [31:0] INDEX_STEP = 32'h0000_0001; // auto increment
    // ****************************************
    // parameter selectors
    // ****************************************
    localparam logic [1:0] SEL_CAPACITY = 2'h0; // array_capacity
    localparam logic [1:0] SEL_INDEX = 2'h1; // array_index
    localparam logic [1:0] SEL_WIN_PRIMARY = 2'h2; // array_window_primary
    localparam logic [1:0] SEL_WIN_SECONDARY = 2'h3; // array_window_secondary
    // ****************************************
    // save unlock codes for system_special_control
    // ****************************************
    localparam logic [31:0] SAVE_CODE_FIRST = 32'h0000_001e; // 30
    localparam logic [31:0] SAVE_CODE_SECOND = 32'h0000_0023; // 35
    // ****************************************
    // save and restore sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        IDAA_RESTORE,
        IDAA_IDLE,
        IDAA_SAVE
    } idaa_seq_t;
endpackage

/* File: hdl/idaa_nv_if.sv */
`timescale 1ns/10ps
// ****************************************
// word port toward nonvolatile backing store
// ****************************************
interface idaa_nv_if;
    import idaa_pkg::*;
    logic rdReq; // read one backed up word
    logic wrReq; // write one word to backing store
    logic [ADDR_WIDTH-1:0] addr; // word address
    logic [WORD_WIDTH-1:0] wrData; // word to save
    logic [WORD_WIDTH-1:0] rdData; // word restored
    logic ack; // access finished
    modport core (output rdReq, wrReq, addr, wrData, input rdData, ack);
    modport store (input rdReq, wrReq, addr, wrData, output rdData, ack);
endinterface

/* File: hdl/idaa_nv_store.sv */
`timescale 1ns/10ps
// ****************************************
// nonvolatile copy of the array
// ****************************************
module idaa_nv_store
    import idaa_pkg::*;
#(
    parameter int DEPTH = ENTRY_COUNT
) (
    input wire logic clk_sys,
    idaa_nv_if.store nv
);
    logic [WORD_WIDTH-1:0] cells [DEPTH]; // retained storage, no reset
    logic [WORD_WIDTH-1:0] rdData_reg; // registered read word
    logic ack_reg; // one cycle done flag

    // write and read port, one cycle latency
    always_ff @(posedge clk_sys) begin
        if (nv.wrReq) begin
            cells[nv.addr] <= nv.wrData;
        end
        rdData_reg <= cells[nv.addr];
        ack_reg <= (nv.rdReq | nv.wrReq) & ~ack_reg;
    end

    assign nv.rdData = rdData_reg;
    assign nv.ack = ack_reg;
endmodule

/* File: hdl/idaa_core.sv */
`timescale 1ns/10ps
module idaa_core
    import idaa_pkg::*;
#(
    parameter int DEPTH = ENTRY_COUNT
) (
    input wire logic clk_sys,
    input wire logic rst,
    // one parameter access from keypad or link
    input wire logic accStrobe,
    input wire logic accWrite,
    input wire logic accFromLink,
    input wire logic [1:0] accSelect,
    input wire logic [WORD_WIDTH-1:0] accWrData,
    // system control parameter writes
    input wire logic ctrlWrite,
    input wire logic [WORD_WIDTH-1:0] ctrlWrData,
    // supply failing, not timed by clk_sys
    input wire logic powerDown,
    // answers, all registered
    output logic [WORD_WIDTH-1:0] accRdData_reg,
    output logic accDone_reg,
    output logic accReject_reg,
    output logic restoreBusy_reg,
    output logic saveArmed_reg,
    output logic saveDone_reg
);
    // ****************************************
    // storage and state
    // ****************************************
    logic signed [WORD_WIDTH-1:0] mem [DEPTH]; // shared array, no regions
    logic [INDEX_WIDTH-1:0] index_reg; // array_index
    // save unlock and power-down pin
    logic firstCode_reg; // first unlock code seen
    logic pdSync1_reg; // power-down sync stage one
    logic pdSync2_reg; // power-down sync stage two
    // save and restore sequencer
    idaa_seq_t seq_reg; // save/restore sequencer
    logic [ADDR_WIDTH-1:0] seqAddr_reg; // sequencer word address
    logic nvPend_reg; // request outstanding

    // ****************************************
    // decode of the access in this cycle
    // ****************************************
    logic inRange; // index points inside array
    logic winAccess; // access through either window
    logic idxWrite; // index parameter written now
    logic doWrite; // store into array this cycle
    logic doStep; // advance index this cycle
    logic reject; // access refused

    // word port toward the backing store
    idaa_nv_if nv ();

    // ****************************************
    // backing store
    // ****************************************
    // retained copy, kept across rst
    idaa_nv_store #(.DEPTH(DEPTH)) u_store (
        .clk_sys(clk_sys),
        .nv(nv)
    );

    // ****************************************
    // decode helpers
    // ****************************************
    // check that a full index selects an entry
    // upper index bits count, so no alias of entry 0
    function automatic logic idx_ok(input logic [INDEX_WIDTH-1:0] idx);
        idx_ok = (idx < INDEX_WIDTH'(DEPTH));
    endfunction

    // either window parameter reaches the array
    function automatic logic is_window(input logic [1:0] sel);
        is_window = (sel == SEL_WIN_PRIMARY) ||
            (sel == SEL_WIN_SECONDARY);
    endfunction

    // last word of a save or reload pass
    function automatic logic last_word(input logic [ADDR_WIDTH-1:0] addr);
        last_word = (addr == ADDR_WIDTH'(DEPTH - 1));
    endfunction

    // ****************************************
    // access decode
    // ****************************************
    // classify one access from keypad or link
    // priority: busy, range, link, keypad window, capacity
    always_comb begin
        inRange = idx_ok(index_reg);
        winAccess = accStrobe && is_window(accSelect);
        idxWrite = (seq_reg == IDAA_IDLE) && accStrobe && accWrite &&
            (accSelect == SEL_INDEX);
        reject = 1'b0;
        doWrite = 1'b0;
        doStep = 1'b0;
        if (seq_reg != IDAA_IDLE) begin
            // reload or save owns the array port
            reject = accStrobe; // busy with save or restore
        end else if (winAccess && !inRange) begin
            // no entry behind the index: touch nothing
            reject = 1'b1;
        end else if (winAccess && accFromLink) begin
            // link: both windows step on read and write
            doWrite = accWrite;
            doStep = 1'b1;
        end else if (winAccess && accSelect == SEL_WIN_PRIMARY) begin
            // keypad primary: only a write steps
            doWrite = accWrite;
            doStep = accWrite;
        end else if (winAccess) begin
            // keypad secondary: read only, steps on read
            reject = accWrite;
            doStep = !accWrite;
        end else if (accStrobe && accWrite &&
                accSelect == SEL_CAPACITY) begin
            // capacity is fixed, writes refused
            reject = 1'b1;
        end
    end

    // ****************************************
    // index register
    // ****************************************
    // written by either accessor, else advanced
    // a write and a step never meet: the decode is exclusive
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // index starts at the first entry
            index_reg <= INDEX_RESET;
        end else if (idxWrite) begin
            // any value is kept, even one past the array
            index_reg <= accWrData;
        end else if (doStep) begin
            // step after the window access is served
            index_reg <= index_reg + INDEX_STEP;
        end
    end

    // ****************************************
    // array write port
    // ****************************************
    // window writes and restore share one port
    // no reset: contents come from the reload
    always_ff @(posedge clk_sys) begin
        if (doWrite) begin
            // in range here, so the low bits name the entry
            mem[index_reg[ADDR_WIDTH-1:0]] <= accWrData;
        end else if (seq_reg == IDAA_RESTORE && nv.ack) begin
            // reloaded word lands as the store answers
            mem[seqAddr_reg] <= nv.rdData;
        end
    end

    // ****************************************
    // read answer
    // ****************************************
    // registered read data and status
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // quiet answer outputs in reset
            accRdData_reg <= '0;
            accDone_reg <= 1'b0;
            accReject_reg <= 1'b0;
        end else begin
            // exactly one of done and reject per access
            accDone_reg <= accStrobe && !reject;
            accReject_reg <= reject;
            // read data only moves on an accepted read
            if (accStrobe && !accWrite && !reject) begin
                case (accSelect)
                    SEL_CAPACITY: accRdData_reg <= CAPACITY_VALUE;
                    SEL_INDEX: accRdData_reg <= index_reg;
                    // either window reads the indexed entry
                    default: accRdData_reg <=
                        mem[index_reg[ADDR_WIDTH-1:0]];
                endcase
            end
        end
    end

    // ****************************************
    // save unlock sequence
    // ****************************************
    // 30 then 35 arms save; other values drop a pending 30, not the arm
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // reset forgets a half entered code pair
            firstCode_reg <= 1'b0;
            saveArmed_reg <= 1'b0;
        end else begin
            // a running save consumes the arm
            if (seq_reg == IDAA_SAVE) begin
                saveArmed_reg <= 1'b0; // consumed by save
            end
            // any control write restarts the code pair
            if (ctrlWrite) begin
                firstCode_reg <= (ctrlWrData == SAVE_CODE_FIRST);
                // second code wins over the clear above
                if (firstCode_reg && ctrlWrData == SAVE_CODE_SECOND) begin
                    saveArmed_reg <= 1'b1;
                end
            end
        end
    end

    // power-down pin synchroniser
    // the pin is asynchronous; only the second stage is read
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pdSync1_reg <= 1'b0;
            pdSync2_reg <= 1'b0;
        end else begin
            pdSync1_reg <= powerDown;
            pdSync2_reg <= pdSync1_reg;
        end
    end

    // ****************************************
    // save and restore sequencer
    // ****************************************
    // restore after reset, save at power-down
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // every reset starts a reload
            seq_reg <= IDAA_RESTORE;
            seqAddr_reg <= '0;
            nvPend_reg <= 1'b0;
            restoreBusy_reg <= 1'b1;
            saveDone_reg <= 1'b0;
        end else begin
            case (seq_reg)
                IDAA_RESTORE: begin
                    // one read per word, none in the cycle its answer is up
                    nvPend_reg <= !nv.ack;
                    if (nv.ack) begin
                        if (last_word(seqAddr_reg)) begin
                            // whole array back, accesses open
                            seq_reg <= IDAA_IDLE;
                            seqAddr_reg <= '0;
                            restoreBusy_reg <= 1'b0;
                        end else begin
                            seqAddr_reg <= seqAddr_reg + 1'b1;
                        end
                    end
                end
                IDAA_IDLE: begin
                    // save once, on power failing after the arm
                    if (pdSync2_reg && saveArmed_reg && !saveDone_reg) begin
                        seq_reg <= IDAA_SAVE;
                        // pass starts from the first word
                        seqAddr_reg <= '0;
                        nvPend_reg <= 1'b0;
                    end
                end
                IDAA_SAVE: begin
                    // one write per word, none in the cycle its answer is up
                    nvPend_reg <= !nv.ack;
                    if (nv.ack) begin
                        if (last_word(seqAddr_reg)) begin
                            // done flag stays until the next reset
                            seq_reg <= IDAA_IDLE;
                            saveDone_reg <= 1'b1;
                        end else begin
                            seqAddr_reg <= seqAddr_reg + 1'b1;
                        end
                    end
                end
                // an illegal code falls back to idle
                default: seq_reg <= IDAA_IDLE;
            endcase
        end
    end

    // ****************************************
    // store requests
    // ****************************************
    // one word at a time, no request in a cycle with ack up
    // held low in reset so the store's done flag settles to zero
    assign nv.rdReq = !rst && (seq_reg == IDAA_RESTORE) && !nvPend_reg &&
        !nv.ack;
    assign nv.wrReq = !rst && (seq_reg == IDAA_SAVE) && !nvPend_reg &&
        !nv.ack;
    // the word under the sequencer goes out unchanged
    assign nv.addr = seqAddr_reg;
    assign nv.wrData = mem[seqAddr_reg];
endmodule

/* File: test/idaa_core_assertions.sv */
`timescale 1ns/10ps
// ****
// port checks for the array access unit
// ****
module idaa_core_assertions
    import idaa_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic accStrobe,
    input wire logic accWrite,
    input wire logic accFromLink,
    input wire logic [1:0] accSelect,
    input wire logic ctrlWrite,
    input wire logic [WORD_WIDTH-1:0] ctrlWrData,
    input wire logic [WORD_WIDTH-1:0] accRdData_reg,
    input wire logic accDone_reg,
    input wire logic accReject_reg,
    input wire logic restoreBusy_reg,
    input wire logic saveArmed_reg,
    input wire logic saveDone_reg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic armSeen_reg; // an arm was seen since reset
    // a save may run from the arm until its done flag
    always_ff @(posedge clk_sys) begin
        armSeen_reg <= !rst && (armSeen_reg || saveArmed_reg);
    end
    // access taken while the sequencer is free
    sequence s_free;
        accStrobe && !restoreBusy_reg && !saveArmed_reg &&
            (!armSeen_reg || saveDone_reg);
    endsequence
    // both unlock codes, back to back
    sequence s_unlock;
        ctrlWrite && ctrlWrData == SAVE_CODE_FIRST ##1
        ctrlWrite && ctrlWrData == SAVE_CODE_SECOND;
    endsequence
    a_one_answer: assert property (
        accStrobe |=> accDone_reg != accReject_reg) else $error("no answer");
    a_quiet_idle: assert property (
        !accStrobe |=> !accDone_reg && !accReject_reg)
        else $error("answer without access");
    a_busy_reject: assert property (
        accStrobe && restoreBusy_reg |=> accReject_reg)
        else $error("access taken during reload");
    a_cap_value: assert property (
        s_free ##0 !accWrite && accSelect == SEL_CAPACITY
        |=> accDone_reg && accRdData_reg == CAPACITY_VALUE)
        else $error("capacity value wrong");
    a_sec_kpd_wr: assert property (
        accStrobe && accWrite && !accFromLink
        && accSelect == SEL_WIN_SECONDARY |=> accReject_reg)
        else $error("keypad secondary write taken");
    a_index_take: assert property (
        s_free ##0 accSelect == SEL_INDEX |=> accDone_reg)
        else $error("index access refused");
    a_save_arm: assert property (
        s_unlock ##0 !saveDone_reg |-> ##[1:2] saveArmed_reg)
        else $error("save not armed");
    a_done_holds: assert property (
        saveDone_reg |=> saveDone_reg) else $error("save done dropped");
    a_restore_first: assert property (
        $fell(rst) |-> restoreBusy_reg) else $error("no reload after reset");
endmodule
bind idaa_core idaa_core_assertions u_chk (.clk_sys(clk_sys), .rst(rst),
    .accStrobe(accStrobe), .accWrite(accWrite), .accFromLink(accFromLink),
    .accSelect(accSelect), .ctrlWrite(ctrlWrite), .ctrlWrData(ctrlWrData),
    .accRdData_reg(accRdData_reg), .accDone_reg(accDone_reg),
    .accReject_reg(accReject_reg), .restoreBusy_reg(restoreBusy_reg),
    .saveArmed_reg(saveArmed_reg), .saveDone_reg(saveDone_reg));

/* File: test/idaa_host_model.sv */
`timescale 1ns/10ps
// ****
// host link and keypad accessor
// ****
module idaa_host_model
    import idaa_pkg::*;
(
    input wire logic clk_sys,
    output logic accStrobe,
    output logic accWrite,
    output logic accFromLink,
    output logic [1:0] accSelect,
    output logic [WORD_WIDTH-1:0] accWrData,
    input wire logic [WORD_WIDTH-1:0] accRdData_reg,
    input wire logic accDone_reg,
    input wire logic accReject_reg
);
    // idle between accesses
    initial begin
        accStrobe = 1'h0;
        accWrite = 1'h0;
        accFromLink = 1'h0;
        accSelect = 2'h0;
        accWrData = 32'h0;
    end
    // one access: raised after a falling edge, taken at the next rise
    task automatic access(input logic [1:0] sel, input logic wr, lnk,
        input logic [31:0] d, output logic [31:0] rd, output logic dn, rj);
        @(negedge clk_sys);
        accSelect = sel;
        accWrite = wr;
        accFromLink = lnk;
        accWrData = d;
        accStrobe = 1'h1;
        @(negedge clk_sys);
        accStrobe = 1'h0;
        accWrData = ~accWrData; // released data is stale
        rd = accRdData_reg;
        dn = accDone_reg;
        rj = accReject_reg;
    endtask
endmodule

/* File: test/test_indexed_data_array_access.sv */
`timescale 1ns/10ps
module test_indexed_data_array_access
    import idaa_pkg::*;
;
    localparam logic WR = 1'h1, RD = 1'h0, LNK = 1'h1, KEY = 1'h0;
    localparam logic NO = 1'h0, YES = 1'h1;
    localparam logic [31:0] Z = 32'h0;
    logic clk_sys, rst, accStrobe, accWrite, accFromLink, ctrlWrite;
    logic powerDown, accDone_reg, accReject_reg, restoreBusy_reg;
    logic saveArmed_reg, saveDone_reg;
    logic [1:0] accSelect;
    logic [WORD_WIDTH-1:0] accWrData, ctrlWrData, accRdData_reg;
    int error_cnt = 0, tests_run = 0, cycles = 0;
    idaa_core uut (.clk_sys(clk_sys), .rst(rst), .accStrobe(accStrobe),
        .accWrite(accWrite), .accFromLink(accFromLink),
        .accSelect(accSelect), .accWrData(accWrData), .ctrlWrite(ctrlWrite),
        .ctrlWrData(ctrlWrData), .powerDown(powerDown),
        .accRdData_reg(accRdData_reg), .accDone_reg(accDone_reg),
        .accReject_reg(accReject_reg), .restoreBusy_reg(restoreBusy_reg),
        .saveArmed_reg(saveArmed_reg), .saveDone_reg(saveDone_reg));
    idaa_host_model host (.clk_sys(clk_sys), .accStrobe(accStrobe),
        .accWrite(accWrite), .accFromLink(accFromLink),
        .accSelect(accSelect), .accWrData(accWrData),
        .accRdData_reg(accRdData_reg), .accDone_reg(accDone_reg),
        .accReject_reg(accReject_reg));
    // free running clock, and a hang limit
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t word %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t flag %b not %b", $time, got, exp);
        end
    endtask
    // access, then check the answer kind and any read data
    task automatic op(input logic [1:0] sel, input logic wr, lnk,
        input logic [31:0] d, input logic rej, input logic [31:0] exp);
        logic [31:0] rd;
        logic dn, rj;
        host.access(sel, wr, lnk, d, rd, dn, rj);
        chk_flag(rj, rej);
        chk_flag(dn, ~rej);
        if (!wr && !rej) chk_word(rd, exp);
    endtask
    // reset, then wait out the reload
    task automatic boot();
        rst = 1'h1;
        repeat (8) @(negedge clk_sys);
        rst = 1'h0;
        chk_flag(restoreBusy_reg, YES);
        op(SEL_INDEX, WR, KEY, 32'h0b, YES, Z);
        while (restoreBusy_reg !== 1'h0) @(negedge clk_sys);
        op(SEL_INDEX, RD, KEY, Z, NO, Z);
    endtask
    initial begin
        ctrlWrite = 1'h0;
        ctrlWrData = 32'h0;
        powerDown = 1'h0;
        boot();
        op(SEL_CAPACITY, RD, LNK, Z, NO, CAPACITY_VALUE);
        op(SEL_CAPACITY, WR, LNK, Z, YES, Z);
        op(SEL_INDEX, WR, KEY, 32'h0b, NO, Z);
        for (int i = 1; i <= 3; i++) begin
            op(SEL_WIN_PRIMARY, WR, KEY, 32'(100 * i), NO, Z);
        end
        op(SEL_INDEX, RD, LNK, Z, NO, 32'h0e);
        op(SEL_INDEX, WR, LNK, 32'h0b, NO, Z);
        op(SEL_WIN_PRIMARY, RD, KEY, Z, NO, 32'h64);
        op(SEL_WIN_PRIMARY, RD, KEY, Z, NO, 32'h64);
        for (int i = 1; i <= 3; i++) begin
            op(SEL_WIN_SECONDARY, RD, KEY, Z, NO, 32'(100 * i));
        end
        op(SEL_WIN_SECONDARY, WR, KEY, 32'h05, YES, Z);
        op(SEL_INDEX, RD, KEY, Z, NO, 32'h0e);
        op(SEL_INDEX, WR, LNK, 32'h14, NO, Z);
        op(SEL_WIN_PRIMARY, WR, LNK, 32'hffff_ffff, NO, Z);
        op(SEL_WIN_SECONDARY, WR, LNK, 32'h0b, NO, Z);
        op(SEL_INDEX, WR, LNK, 32'h14, NO, Z);
        op(SEL_WIN_SECONDARY, RD, LNK, Z, NO, 32'hffff_ffff);
        op(SEL_WIN_PRIMARY, RD, LNK, Z, NO, 32'h0b);
        op(SEL_INDEX, RD, LNK, Z, NO, 32'h16);
        op(SEL_INDEX, WR, LNK, 32'h31f, NO, Z);
        op(SEL_WIN_PRIMARY, WR, LNK, 32'h07, NO, Z);
        op(SEL_WIN_SECONDARY, WR, LNK, 32'h08, YES, Z);
        op(SEL_WIN_PRIMARY, RD, KEY, Z, YES, Z);
        op(SEL_INDEX, RD, KEY, Z, NO, 32'h320);
        op(SEL_INDEX, WR, KEY, 32'h31f, NO, Z);
        op(SEL_WIN_PRIMARY, RD, KEY, Z, NO, 32'h07);
        // unlock codes back to back, drive output assumed off
        @(negedge clk_sys);
        ctrlWrite = 1'h1;
        ctrlWrData = SAVE_CODE_FIRST;
        @(negedge clk_sys);
        ctrlWrData = SAVE_CODE_SECOND;
        @(negedge clk_sys);
        ctrlWrite = 1'h0;
        @(negedge clk_sys);
        chk_flag(saveArmed_reg, YES);
        chk_flag(saveDone_reg, NO);
        powerDown = 1'h1;
        while (saveDone_reg !== 1'h1) @(negedge clk_sys);
        chk_flag(saveArmed_reg, NO);
        powerDown = 1'h0;
        boot();
        op(SEL_INDEX, WR, KEY, 32'h0b, NO, Z);
        op(SEL_WIN_SECONDARY, RD, KEY, Z, NO, 32'h64);
        op(SEL_WIN_SECONDARY, RD, KEY, Z, NO, 32'hc8);
        conclude();
    end
endmodule
